// file: verilog/bgc_baud_gen.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module bgc_baud_gen #(
    parameter int DIV_WIDTH = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_in_pin,
    input  wire logic        ext_tx_clock_in,
    input  wire logic        ext_rx_clock_in,
    input  wire logic        carrier_detect_gate,
    output logic             rx_data,
    output logic             rx_tick,
    output logic             tx_tick,
    output logic             baud_clk,
    output logic             txrx_enable,
    output logic             txrx_reset
);

    logic [7:0]           div_msb_hold;
    logic [DIV_WIDTH-1:0] divisor;
    logic [DIV_WIDTH-1:0] cnt;
    logic [3:0]           rx_pre;
    logic [3:0]           tx_pre;
    logic [2:0]           clock_ctrl;
    logic [1:0]           sync_in;
    logic                 running;
    logic                 sin_s1;
    logic                 sin_s2;
    logic                 rxc_s1;
    logic                 rxc_s2;
    logic                 rxc_s3;
    logic                 txc_s1;
    logic                 txc_s2;
    logic                 txc_s3;
    logic                 dcd_s1;
    logic                 dcd_s2;

    logic                 setup;
    logic                 wr_access;
    logic                 wr_msb;
    logic                 wr_lsb;
    logic [DIV_WIDTH-1:0] new_div;
    logic                 div_ok;
    logic                 clock_divide_select;
    logic                 ext_rx_clock_enable;
    logic                 ext_tx_clock_select;
    logic                 sync_mode_enable;
    logic                 dcd_active;
    logic                 rx_rise;
    logic                 tx_rise;
    logic                 src_tick;
    logic                 baud_hit;
    logic [DIV_WIDTH-1:0] next_cnt;
    logic                 rx_gate;
    logic                 ext_tx_hit;

    // One step of a divide-by-sixteen prescaler.
    function automatic logic [3:0] pre_step(input logic [3:0] pre, input logic hit);
        pre_step = hit ? pre + 4'h1 : pre;
    endfunction

    assign setup     = psel && !penable;
    assign wr_access = ce && psel && penable && pready && pwrite;
    assign wr_msb    = wr_access && (paddr == bgc_pkg::ADDR_DIV_MSB);
    assign wr_lsb    = wr_access && (paddr == bgc_pkg::ADDR_DIV_LSB);
    assign new_div   = {div_msb_hold, pwdata[7:0]};

    assign clock_divide_select = clock_ctrl[bgc_pkg::CLK_DIVIDE_SELECT_BIT];
    assign ext_rx_clock_enable = clock_ctrl[bgc_pkg::EXT_RX_CLOCK_ENABLE_BIT];
    assign ext_tx_clock_select = clock_ctrl[bgc_pkg::EXT_TX_CLOCK_SELECT_BIT];
    assign sync_mode_enable    = sync_in[bgc_pkg::SYNC_MODE_ENABLE_BIT];

    assign div_ok = divisor >= bgc_pkg::DIVISOR_MIN;

    assign dcd_active = sync_mode_enable && (dcd_s2 == sync_in[bgc_pkg::DCD_ACTIVE_HIGH_BIT]);

    assign rx_rise = rxc_s2 && !rxc_s3;
    assign tx_rise = txc_s2 && !txc_s3;

    assign src_tick = ext_rx_clock_enable ? rx_rise : 1'b1;

    assign baud_hit = ce && running && div_ok && src_tick && (cnt <= 16'h0001);

    assign next_cnt = (cnt <= 16'h0001) ? divisor : cnt - 16'h0001;

    // Outside synchronous mode the carrier pin is ignored and the receiver clock passes.
    // carrier gate in sync mode
    assign rx_gate = !sync_mode_enable || dcd_active;

    // An external transmit clock counts only while running, so a high byte write stops it and a low byte write restarts it.
    assign ext_tx_hit = ce && running && tx_rise;

    // Clock pins carry a third flop so each rising edge is seen once, from settled values.
    // two-stage input synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sin_s1 <= 1'b1;
            sin_s2 <= 1'b1;
            rxc_s1 <= 1'b0;
            rxc_s2 <= 1'b0;
            rxc_s3 <= 1'b0;
            txc_s1 <= 1'b0;
            txc_s2 <= 1'b0;
            txc_s3 <= 1'b0;
            dcd_s1 <= 1'b0;
            dcd_s2 <= 1'b0;
        end else if (ce) begin
            sin_s1 <= serial_in_pin;
            sin_s2 <= sin_s1;
            rxc_s1 <= ext_rx_clock_in;
            rxc_s2 <= rxc_s1;
            rxc_s3 <= rxc_s2;
            txc_s1 <= ext_tx_clock_in;
            txc_s2 <= txc_s1;
            txc_s3 <= txc_s2;
            dcd_s1 <= carrier_detect_gate;
            dcd_s2 <= dcd_s1;
        end
    end

    // Data reaches the receiver with the synchroniser latency and nothing else.
    assign rx_data = sin_s2;

    // APB slave: zero wait states, read data captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (setup) begin
                case (paddr)
                    bgc_pkg::ADDR_DIV_MSB:      prdata[7:0] <= div_msb_hold;
                    bgc_pkg::ADDR_DIV_LSB:      prdata[7:0] <= divisor[7:0];
                    bgc_pkg::ADDR_CLOCK_CTRL:   prdata[2:0] <= clock_ctrl;
                    bgc_pkg::ADDR_SYNC_IN_CTRL: prdata[1:0] <= sync_in;
                    bgc_pkg::ADDR_STATUS: begin
                        prdata[bgc_pkg::STAT_RUNNING_BIT]    <= running;
                        prdata[bgc_pkg::STAT_BAUD_CLK_BIT]   <= baud_clk;
                        prdata[bgc_pkg::STAT_DCD_ACTIVE_BIT] <= dcd_active;
                        prdata[bgc_pkg::STAT_HALTED_BIT]     <= !div_ok;
                    end
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Control registers; writes to status or unmapped words are ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_ctrl <= bgc_pkg::CLOCK_CTRL_RESET;
            sync_in    <= bgc_pkg::SYNC_IN_RESET;
        end else if (wr_access) begin
            if (paddr == bgc_pkg::ADDR_CLOCK_CTRL) begin
                clock_ctrl <= pwdata[2:0];
            end
            if (paddr == bgc_pkg::ADDR_SYNC_IN_CTRL) begin
                sync_in <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_msb_hold <= bgc_pkg::DIV_MSB_RESET;
            divisor      <= bgc_pkg::DIVISOR_RESET;
        end else if (wr_msb) begin
            div_msb_hold <= pwdata[7:0];
        end else if (wr_lsb) begin
            divisor <= new_div;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running    <= 1'b0;
            txrx_reset <= 1'b1;
        end else if (ce) begin
            txrx_reset <= wr_msb || wr_lsb;
            if (wr_msb) begin
                running <= 1'b0;
            end else if (wr_lsb) begin
                running <= 1'b1;
            end
        end
    end

    assign txrx_enable = running;

    // The counter reloads on the cycle it reaches one, so N input ticks make one period.
    // A high byte write clears the output at once; a low byte write sets it high if the new divisor is at least two.
    // counter load and half-period output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= bgc_pkg::DIVISOR_RESET;
            baud_clk <= 1'b0;
        end else if (wr_msb) begin
            cnt      <= bgc_pkg::DIVISOR_RESET;
            baud_clk <= 1'b0;
        end else if (wr_lsb) begin
            cnt      <= new_div;
            baud_clk <= new_div >= bgc_pkg::DIVISOR_MIN;
        end else if (ce && running && div_ok && src_tick) begin
            cnt      <= next_cnt;
            baud_clk <= next_cnt > (divisor >> 1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pre  <= 4'h0;
            tx_pre  <= 4'h0;
            rx_tick <= 1'b0;
            tx_tick <= 1'b0;
        end else if (wr_msb || wr_lsb) begin
            rx_pre  <= 4'h0;
            tx_pre  <= 4'h0;
            rx_tick <= 1'b0;
            tx_tick <= 1'b0;
        end else if (ce) begin
            rx_pre  <= pre_step(rx_pre, baud_hit);
            tx_pre  <= pre_step(tx_pre, ext_tx_hit);
            rx_tick <= baud_hit && rx_gate
                       && (clock_divide_select || rx_pre == bgc_pkg::PRESCALE_LAST);
            if (ext_tx_clock_select) begin
                tx_tick <= ext_tx_hit
                           && (clock_divide_select || tx_pre == bgc_pkg::PRESCALE_LAST);
            end else begin
                tx_tick <= baud_hit
                           && (clock_divide_select || rx_pre == bgc_pkg::PRESCALE_LAST);
            end
        end
    end

    // Checks kept beside the logic.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence low_byte_write_s;
        wr_lsb && pwdata[7:0] == 8'h04 && div_msb_hold == 8'h00;
    endsequence

    sequence counting_start_s;
        running && cnt == 16'h0004 && baud_clk;
    endsequence

    halt_low_div_a: assert property (
        !div_ok |-> !baud_hit && !baud_clk
                    && ($stable(cnt) || $past(wr_msb || wr_lsb || div_ok)))
        else $error("Divider ran with a divisor below two.");

    write_resets_a: assert property (
        wr_msb && ce |=> txrx_reset && !txrx_enable && cnt == 16'h0000)
        else $error("High byte write did not reset the block.");

    lsb_starts_a: assert property (
        low_byte_write_s |=> counting_start_s)
        else $error("Low byte write did not load and start the counter.");

    msb_held_a: assert property (
        wr_msb |=> $stable(divisor))
        else $error("High byte write disturbed the running divisor.");

    half_period_a: assert property (
        low_byte_write_s ##1 (ce && !ext_rx_clock_enable)[*2] |=> !baud_clk)
        else $error("Baud clock not low in second half of period.");

    dcd_gate_a: assert property (
        rx_tick && sync_mode_enable |-> $past(dcd_active))
        else $error("Receive clock passed while carrier detect inactive.");

    undivided_a: assert property (
        ce && clock_divide_select && !sync_mode_enable && baud_hit
        && !wr_msb && !wr_lsb |=> rx_tick)
        else $error("Undivided mode dropped a bit clock tick.");

    div16_a: assert property (
        rx_tick && !clock_divide_select |-> $past(rx_pre) == 4'hF)
        else $error("Sixteen-times mode ticked off the prescaler wrap.");

    ext_rx_src_a: assert property (
        ext_rx_clock_enable && running && !rx_rise && !wr_lsb && !wr_msb |=> $stable(cnt))
        else $error("Divider stepped without an external receive edge.");

    sin_sync_a: assert property (
        (ce && presetn) [*3] |-> rx_data == $past(serial_in_pin, 2))
        else $error("Serial data not delayed by exactly two flops.");

    reset_pulse_a: assert property (
        presetn && txrx_reset && !wr_msb && !wr_lsb |=> !txrx_reset)
        else $error("Transmitter and receiver reset stood longer than one cycle.");

    ce_freeze_a: assert property (
        !ce |=> $stable(cnt) && $stable(running) && $stable(baud_clk) && $stable(rx_tick))
        else $error("State moved while the clock enable was low.");

endmodule

`default_nettype wire

// file: verilog/bgc_pkg.sv
package bgc_pkg;

    // Register byte offsets on the APB port.
    localparam logic [7:0] ADDR_DIV_MSB     = 8'h00;
    localparam logic [7:0] ADDR_DIV_LSB     = 8'h04;
    localparam logic [7:0] ADDR_CLOCK_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_SYNC_IN_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS      = 8'h10;

    // Field positions in clock_ctrl.
    localparam int CLK_DIVIDE_SELECT_BIT = 0;
    localparam int EXT_RX_CLOCK_ENABLE_BIT = 1;
    localparam int EXT_TX_CLOCK_SELECT_BIT = 2;

    // Field positions in sync_in.
    localparam int SYNC_MODE_ENABLE_BIT = 0;
    localparam int DCD_ACTIVE_HIGH_BIT  = 1;

    // Field positions in status.
    localparam int STAT_RUNNING_BIT = 0;
    localparam int STAT_BAUD_CLK_BIT = 1;
    localparam int STAT_DCD_ACTIVE_BIT = 2;
    localparam int STAT_HALTED_BIT  = 3;

    // Reset values.
    localparam logic [15:0] DIVISOR_RESET    = 16'h0000;
    localparam logic [7:0]  DIV_MSB_RESET    = 8'h00;
    localparam logic [2:0]  CLOCK_CTRL_RESET = 3'h0;
    localparam logic [1:0]  SYNC_IN_RESET    = 2'h0;

    // Divider limits and the asynchronous-mode factor.
    localparam logic [15:0] DIVISOR_MIN = 16'h0002;
    localparam logic [3:0]  PRESCALE_LAST = 4'hF;

endpackage

// file: bench/bgc_remote_model.sv
`timescale 1ns/100ps
`default_nettype none

module bgc_remote_model (
    input  wire logic frame,
    input  wire logic pclk,
    input  wire logic dcd_level,
    output logic      ext_rx_clock_in,
    output logic      ext_tx_clock_in,
    output logic      serial_in_pin,
    output logic      carrier_detect_gate
);
    logic [1:0] cnt = 2'd0;
    logic       lead = 1'b0;
    initial begin
        ext_rx_clock_in = 1'b0;
        ext_tx_clock_in = 1'b0;
        serial_in_pin = 1'b0;
        carrier_detect_gate = 1'b0;
    end
    always @(posedge pclk) begin
        if (!frame) begin
            // Clocks stand still and the idle data line keeps changing, so no stale level helps.
            cnt <= 2'd0;
            lead <= 1'b0;
            ext_rx_clock_in <= 1'b0;
            ext_tx_clock_in <= 1'b0;
            serial_in_pin <= ~serial_in_pin;
            carrier_detect_gate <= ~dcd_level;
        end else begin
            carrier_detect_gate <= dcd_level;
            lead <= 1'b1;
            if (lead) begin
                cnt <= cnt + 2'd1;
            end
            if (lead && cnt[0]) begin
                ext_rx_clock_in <= ~ext_rx_clock_in;
                ext_tx_clock_in <= ~ext_tx_clock_in;
                if (ext_rx_clock_in) begin
                    serial_in_pin <= ~serial_in_pin;
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: bench/test_serial_baud_gen_and_clock_inputs.sv
`timescale 1ns/100ps
`default_nettype none

module test_serial_baud_gen_and_clock_inputs;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        frame = 1'b0;
    logic        dcd_level = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] prdata;
    logic        pready, pslverr, rx_data, rx_tick, tx_tick, baud_clk, txrx_enable, txrx_reset;
    logic        ext_rx_clock_in, ext_tx_clock_in, serial_in_pin, carrier_detect_gate;
    int          failures = 0;
    int          checks_done = 0;

    always #4 pclk = ~pclk;

    bgc_baud_gen dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
        .ext_tx_clock_in(ext_tx_clock_in), .ext_rx_clock_in(ext_rx_clock_in),
        .carrier_detect_gate(carrier_detect_gate), .rx_data(rx_data), .rx_tick(rx_tick),
        .tx_tick(tx_tick), .baud_clk(baud_clk), .txrx_enable(txrx_enable),
        .txrx_reset(txrx_reset));
    bgc_remote_model far_u (.frame(frame), .pclk(pclk), .dcd_level(dcd_level),
        .ext_rx_clock_in(ext_rx_clock_in), .ext_tx_clock_in(ext_tx_clock_in),
        .serial_in_pin(serial_in_pin), .carrier_detect_gate(carrier_detect_gate));

    task automatic results;
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic stop;
        failures++;
        results();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) stop();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'h00_0000, d}, q, e);
        chk("write error", 32'h0000_0000, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                      input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk("read data", x, q & m);
        chk("read error", {31'h0, xe}, {31'h0, e});
    endtask
    function automatic logic sig(input int w);
        return (w == 0) ? baud_clk : (w == 1) ? tx_tick : rx_tick;
    endfunction
    task automatic wait_lvl(input int w, input logic v);
        int n;
        for (n = 0; sig(w) !== v; n++) begin
            if (n > 3000) stop();
            @(posedge pclk);
        end
    endtask
    // Measures one period of baud_clk (0), tx_tick (1) or rx_tick (2) and its high cycles.
    task automatic gap(input int w, input int len_x, input int hi_x);
        int   len = 0;
        int   hi = 0;
        logic p = 1'b1;
        wait_lvl(w, 1'b0);
        wait_lvl(w, 1'b1);
        while (!(p === 1'b0 && sig(w) === 1'b1) && len < 3000) begin
            hi += (sig(w) === 1'b1);
            p = sig(w);
            @(posedge pclk);
            len++;
        end
        if (len >= 3000) stop();
        chk("period", len_x, len);
        chk("high cycles", hi_x, hi);
    endtask
    task automatic quiet(input int w);
        int n = 0;
        repeat (40) begin
            @(posedge pclk);
            n += (sig(w) !== 1'b0);
        end
        chk("activity", 0, n);
    endtask
    task automatic rst_pulses;
        int n = 0;
        repeat (4) begin
            @(posedge pclk);
            n += (txrx_reset === 1'b1);
        end
        chk("txrx_reset pulses", 1, n);
    endtask
    // Software order: high byte, setup, low byte, with the far side quiet.
    // ordered idle setup
    task automatic prog(input logic [7:0] msb, input logic [7:0] ctrl,
                        input logic [7:0] sync, input logic [7:0] lsb);
        frame <= 1'b0;
        wr(bgc_pkg::ADDR_DIV_MSB, msb);
        rst_pulses();
        chk("txrx_enable", 0, txrx_enable);
        wr(bgc_pkg::ADDR_CLOCK_CTRL, ctrl);
        wr(bgc_pkg::ADDR_SYNC_IN_CTRL, sync);
        wr(bgc_pkg::ADDR_DIV_LSB, lsb);
        rst_pulses();
        chk("txrx_enable", 1, txrx_enable);
    endtask

    task automatic s_reset;
        chk("txrx_reset", 1, txrx_reset);
        chk("baud_clk", 0, baud_clk);
        @(posedge pclk);
        presetn <= 1'b1;
        rd(bgc_pkg::ADDR_DIV_MSB, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        rd(bgc_pkg::ADDR_CLOCK_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        rd(bgc_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0008, 1'b0);
        rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    endtask
    task automatic s_divide;
        int n = 0;
        prog(8'h00, 8'h01, 8'h00, 8'h06);
        while (tx_tick !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) stop();
        chk("first tick soon", 1, (n >= 2 && n <= 9));
        gap(0, 6, 3);
        gap(1, 6, 1);
        gap(2, 6, 1);
        rd(bgc_pkg::ADDR_DIV_LSB, 32'h0000_00FF, 32'h0000_0006, 1'b0);
        rd(bgc_pkg::ADDR_STATUS, 32'h0000_0009, 32'h0000_0001, 1'b0);
        prog(8'h01, 8'h01, 8'h00, 8'h00);
        rd(bgc_pkg::ADDR_DIV_MSB, 32'h0000_00FF, 32'h0000_0001, 1'b0);
        gap(0, 256, 128);
        prog(8'h00, 8'h00, 8'h00, 8'h04);
        gap(1, 64, 1);
        gap(2, 64, 1);
    endtask
    task automatic s_halt;
        for (int d = 0; d < 2; d++) begin
            prog(8'h00, 8'h01, 8'h00, d[7:0]);
            quiet(0);
            quiet(1);
            rd(bgc_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0008, 1'b0);
        end
    endtask
    task automatic s_ext;
        prog(8'h00, 8'h03, 8'h00, 8'h02);
        frame <= 1'b1;
        gap(2, 8, 1);
        gap(1, 8, 1);
        prog(8'h00, 8'h07, 8'h00, 8'h02);
        frame <= 1'b1;
        gap(1, 4, 1);
        prog(8'h00, 8'h06, 8'h00, 8'h02);
        frame <= 1'b1;
        gap(1, 64, 1);
        prog(8'h00, 8'h01, 8'h00, 8'h02);
        frame <= 1'b1;
        gap(2, 2, 1);
    endtask
    task automatic s_sync;
        dcd_level <= 1'b1;
        prog(8'h00, 8'h03, 8'h03, 8'h02);
        frame <= 1'b1;
        gap(2, 8, 1);
        rd(bgc_pkg::ADDR_SYNC_IN_CTRL, 32'h0000_0003, 32'h0000_0003, 1'b0);
        rd(bgc_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0004, 1'b0);
        prog(8'h00, 8'h03, 8'h01, 8'h02);
        frame <= 1'b1;
        quiet(2);
        frame <= 1'b0;
        dcd_level <= 1'b0;
        @(posedge pclk);
        frame <= 1'b1;
        gap(2, 8, 1);
        prog(8'h00, 8'h03, 8'h02, 8'h02);
        frame <= 1'b1;
        gap(2, 8, 1);
    endtask
    task automatic s_rxdata;
        logic [1:0] hist = 2'b00;
        frame <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            @(posedge pclk);
            if (i > 2) chk("rx_data", {31'h0, hist[1]}, {31'h0, rx_data});
            hist = {hist[0], serial_in_pin};
        end
    endtask

    // Clock enable low must freeze the divider and its registered outputs.
    task automatic s_freeze;
        logic [2:0] held;
        int         n = 0;
        prog(8'h00, 8'h01, 8'h00, 8'h06);
        ce <= 1'b0;
        @(posedge pclk);
        held = {baud_clk, tx_tick, rx_tick};
        repeat (20) begin
            @(posedge pclk);
            n += ({baud_clk, tx_tick, rx_tick} !== held);
        end
        chk("frozen outputs", 0, n);
        ce <= 1'b1;
        gap(0, 6, 3);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        s_reset();
        s_divide();
        s_halt();
        s_ext();
        s_sync();
        s_rxdata();
        s_freeze();
        results();
    end
endmodule

`default_nettype wire
